// [design/rbmc_reset_boot.sv]
// Purpose: releases internal reset after a fixed count and captures boot straps
// Assumes: straps and flash security are stable around reset release
// Notes: strap pins are asynchronous and pass two flip-flops before use
`timescale 1ns/1ps
module rbmc_reset_boot
  import rbmc_pkg::*;
#(
  parameter int unsigned RELEASE_CYCLES = RBMC_RELEASE_CYCLES
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // straps and flash state
  input wire logic BOOT_SOURCE_STRAP_I,
  input wire logic EXT_MEM_WIDTH_STRAP_I,
  input wire logic FLASH_UNSECURED_I,
  // pull-up control from boot software
  input wire logic BOOT_STRAP_PULLUP_DISABLE_I,
  input wire logic WIDTH_STRAP_PULLUP_DISABLE_I,
  // internal reset and captured mode
  output logic INT_RST_N_O,
  output logic PROGRAM_MAP_SELECT_O,
  output logic SECURE_STATE_CAPTURE_O,
  output logic EXT_MEM_WIDE_O,
  output logic [3:0] UPPER_ADDR_PIN_EN_O,
  // strap pull-up enables
  output logic BOOT_STRAP_PULLUP_EN_O,
  output logic WIDTH_STRAP_PULLUP_EN_O
);
  // ****************************************
  // synchronisers
  // ****************************************
  logic boot_s1_q, boot_s2_q, wid_s1_q, wid_s2_q, sec_s1_q, sec_s2_q;
  // first stages are read only by second stages
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {boot_s1_q, boot_s2_q, wid_s1_q, wid_s2_q, sec_s1_q, sec_s2_q} <= 6'h00;
    end else begin
      boot_s1_q <= BOOT_SOURCE_STRAP_I;
      boot_s2_q <= boot_s1_q;
      wid_s1_q <= EXT_MEM_WIDTH_STRAP_I;
      wid_s2_q <= wid_s1_q;
      sec_s1_q <= FLASH_UNSECURED_I;
      sec_s2_q <= sec_s1_q;
    end
  end

  // ****************************************
  // release sequencer
  // ****************************************
  // upper-address pin enables for a width choice; only pins_next uses it, the checks spell it out
  function automatic logic [3:0] pin_sel(input logic wide_bus);
    return wide_bus ? RBMC_PINS_ADDR : RBMC_PINS_GPIO;
  endfunction

  localparam logic [RBMC_CNT_W-1:0] LAST_CNT = RBMC_CNT_W'(RELEASE_CYCLES - 1);
  rbmc_state_t state_q, state_d;
  logic [RBMC_CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] sync_wait_q;
  wire cnt_done = (cnt_q == LAST_CNT);
  // the synchronisers restart from zero at every reset, so capture waits until
  // both stages hold levels sampled after release; earlier would latch internal boot
  wire capture = (state_q == RBMC_ST_SYNC) && (sync_wait_q == 2'b00);
  // external boot granted only when unsecured, else both bits fall to zero
  wire ext_ok = boot_s2_q & sec_s2_q;
  wire wide = ext_ok & wid_s2_q;
  wire [3:0] pins_next = pin_sel(wide);

  // wait two cycles so synchronisers hold valid strap levels, then count
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RBMC_ST_SYNC: begin
        state_d = RBMC_ST_COUNT;
      end
      RBMC_ST_COUNT: begin
        if (cnt_done) begin
          state_d = RBMC_ST_RUN;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = RBMC_ST_RUN;
      end
    endcase
  end

  // two-bit shift marks the two edges the synchronisers need after release
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= RBMC_ST_SYNC;
      cnt_q <= '0;
      sync_wait_q <= 2'b11;
    end else begin
      sync_wait_q <= {sync_wait_q[0], 1'b0};
      // hold SYNC while the second stages still show their reset value
      state_q <= (sync_wait_q != 2'b00) ? RBMC_ST_SYNC : state_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // captured mode, held until next reset
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      INT_RST_N_O <= 1'b0;
      PROGRAM_MAP_SELECT_O <= RBMC_MAP_RST;
      SECURE_STATE_CAPTURE_O <= RBMC_SEC_RST;
      EXT_MEM_WIDE_O <= 1'b0;
      UPPER_ADDR_PIN_EN_O <= RBMC_PINS_GPIO;
    end else begin
      // state_d reaches RUN only from COUNT, which the sync wait has already passed
      INT_RST_N_O <= (state_d == RBMC_ST_RUN);
      if (capture) begin
        PROGRAM_MAP_SELECT_O <= ext_ok;
        // secure bit mirrors the flash state, so an internal boot on open flash reads 1
        SECURE_STATE_CAPTURE_O <= sec_s2_q;
        EXT_MEM_WIDE_O <= wide;
        UPPER_ADDR_PIN_EN_O <= pins_next;
      end
    end
  end

  // pull-ups on at reset, software turns them off for tied-low straps
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BOOT_STRAP_PULLUP_EN_O <= 1'b1;
      WIDTH_STRAP_PULLUP_EN_O <= 1'b1;
    end else begin
      BOOT_STRAP_PULLUP_EN_O <= !BOOT_STRAP_PULLUP_DISABLE_I;
      WIDTH_STRAP_PULLUP_EN_O <= !WIDTH_STRAP_PULLUP_DISABLE_I;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [RBMC_CNT_W:0] rel_cnt_q;
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rel_cnt_q <= '0;
    end else if (!INT_RST_N_O) begin
      rel_cnt_q <= rel_cnt_q + 1'b1;
    end
  end

  a_release_count: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(INT_RST_N_O) |-> rel_cnt_q == (RBMC_CNT_W+1)'(RELEASE_CYCLES + 3))
    else $error("internal reset released at wrong cycle");
  a_release_sticky: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    INT_RST_N_O |=> INT_RST_N_O)
    else $error("internal reset reasserted without pin reset");
  a_secure_fallback: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    PROGRAM_MAP_SELECT_O |-> SECURE_STATE_CAPTURE_O)
    else $error("external map selected on secured flash");
  a_wide_ext_only: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    EXT_MEM_WIDE_O |-> PROGRAM_MAP_SELECT_O)
    else $error("wide bus without external boot");
  a_pins_follow: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    UPPER_ADDR_PIN_EN_O == (EXT_MEM_WIDE_O ? RBMC_PINS_ADDR : RBMC_PINS_GPIO))
    else $error("upper address pins mismatch");
  a_mode_frozen: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    INT_RST_N_O |=> $stable(PROGRAM_MAP_SELECT_O))
    else $error("boot mode changed after release");
  a_capture_value: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    capture |=> PROGRAM_MAP_SELECT_O == $past(ext_ok))
    else $error("boot mode not captured");
  a_narrow_internal: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (INT_RST_N_O && !PROGRAM_MAP_SELECT_O) |-> !EXT_MEM_WIDE_O)
    else $error("internal boot with wide bus");
  a_pullup_follow: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    BOOT_STRAP_PULLUP_DISABLE_I |=> !BOOT_STRAP_PULLUP_EN_O)
    else $error("boot strap pull-up not disabled");
  a_width_pullup: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    WIDTH_STRAP_PULLUP_DISABLE_I |=> !WIDTH_STRAP_PULLUP_EN_O)
    else $error("width strap pull-up not disabled");
  a_pullup_restore: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !BOOT_STRAP_PULLUP_DISABLE_I |=> BOOT_STRAP_PULLUP_EN_O)
    else $error("boot strap pull-up stuck off");

  // ****************************************
  // release and capture steps
  // ****************************************
  // the count has run out while the internal reset is still held
  sequence s_count_full;
    !INT_RST_N_O && (rel_cnt_q == (RBMC_CNT_W+1)'(RELEASE_CYCLES + 2));
  endsequence
  // internal reset has been lifted
  sequence s_released;
    INT_RST_N_O;
  endsequence
  // capture edge with the flash reported secured
  sequence s_capture_secured;
    capture && !sec_s2_q;
  endsequence
  // capture edge with an external request on open flash
  sequence s_capture_external;
    capture && boot_s2_q && sec_s2_q;
  endsequence
  // capture edge with the width strap low
  sequence s_capture_narrow;
    capture && !wid_s2_q;
  endsequence

  // reset must come off on the edge after the count, never later
  a_release_happens: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_count_full |=> s_released)
    else $error("internal reset held past its count");
  a_secured_fallback: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_capture_secured |=> !PROGRAM_MAP_SELECT_O && !SECURE_STATE_CAPTURE_O)
    else $error("secured flash did not fall back to internal boot");
  a_external_granted: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_capture_external |=> PROGRAM_MAP_SELECT_O)
    else $error("external boot request not honoured");
  a_narrow_strap: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_capture_narrow |=> !EXT_MEM_WIDE_O && (UPPER_ADDR_PIN_EN_O == RBMC_PINS_GPIO))
    else $error("narrow strap gave wide bus");
  a_secure_capture: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    capture |=> SECURE_STATE_CAPTURE_O == $past(sec_s2_q))
    else $error("secure state not captured");
  a_rest_frozen: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    INT_RST_N_O |=> $stable(SECURE_STATE_CAPTURE_O) && $stable(EXT_MEM_WIDE_O) && $stable(UPPER_ADDR_PIN_EN_O))
    else $error("captured configuration changed after release");
  a_state_legal: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    state_q inside {RBMC_ST_SYNC, RBMC_ST_COUNT, RBMC_ST_RUN})
    else $error("release sequencer in unknown state");
  // checked one edge later so power-up before the first reset edge cannot trip it
  a_reset_clears: assert property (@(posedge CLOCK_I)
    !RST_N_I |=> !INT_RST_N_O && (PROGRAM_MAP_SELECT_O == RBMC_MAP_RST) && (SECURE_STATE_CAPTURE_O == RBMC_SEC_RST)
      && !EXT_MEM_WIDE_O && (UPPER_ADDR_PIN_EN_O == RBMC_PINS_GPIO))
    else $error("outputs not cleared by reset");
endmodule

// [design/rbmc_pkg.sv]
// Purpose: constants for the reset release and boot mode capture block
// Assumes: one 100 MHz system clock, active-low asynchronous reset
// Notes: no register bus; configuration and status are plain ports
//
// Overview of operation
// - reset low keeps all state initialised
// - capture boot strap when reset releases
// - internal reset held fixed cycles, then synchronous
// - board strap high external, low internal boot
// - external boot only when flash unsecured
// - width strap low keeps narrow bus
// - map and secure bits loaded; secured falls to 00
// - external boot takes memory width from strap
// - wide strap on external boot turns four pins into addresses
package rbmc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned RBMC_RELEASE_CYCLES = 32;
  localparam int unsigned RBMC_CNT_W = 16;
  // ****************************************
  // reset values and widths
  // ****************************************
  localparam logic RBMC_MAP_RST = 1'b0;
  localparam logic RBMC_SEC_RST = 1'b0;
  localparam int unsigned RBMC_UPPER_ADDR_PINS = 4;
  localparam logic [3:0] RBMC_PINS_GPIO = 4'h0;
  localparam logic [3:0] RBMC_PINS_ADDR = 4'hf;

  typedef enum logic [1:0] {
    RBMC_ST_SYNC = 2'b00,
    RBMC_ST_COUNT = 2'b01,
    RBMC_ST_RUN = 2'b10
  } rbmc_state_t;
endpackage

// [verification/rbmc_board.sv]
// Purpose: board reset source and strap wiring
// Assumes: straps are tied hard, never left floating
// Notes: pull-ups only matter for a floating strap
`timescale 1ns/1ps
module rbmc_board (
  // requests from the bench
  input wire logic hold_rst_i,
  input wire logic src_hi_i,
  input wire logic wide_hi_i,
  // board nets
  output logic rst_n_o,
  output logic trst_n_o,
  output logic src_strap_o,
  output logic width_strap_o
);
  // both resets move together so debug logic is cleared too
  assign rst_n_o = ~hold_rst_i;
  assign trst_n_o = ~hold_rst_i;
  // straps tied to supply or ground
  assign src_strap_o = src_hi_i;
  assign width_strap_o = wide_hi_i;
endmodule

// [verification/reset_boot_mode_capture_test.sv]
// Purpose: self-checking bench for reset release and boot capture
// Assumes: release count cut to 4 to keep runs short
// Notes: straps settle during reset, well ahead of capture
`timescale 1ns/1ps
module reset_boot_mode_capture_test;
  import rbmc_pkg::*;
  localparam int unsigned RC = 4;
  logic clk = 1'b0;
  logic hold = 1'b1;
  logic src = 1'b0;
  logic wid = 1'b0;
  logic unsec = 1'b0;
  logic bpd = 1'b0;
  logic wpd = 1'b0;
  logic rst_n, s_strap, w_strap, irst_n, map, sec, wide, bpe, wpe;
  logic [3:0] pins;
  logic [6:0] e;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  rbmc_board rbmc_board_i (.hold_rst_i(hold), .src_hi_i(src), .wide_hi_i(wid), .rst_n_o(rst_n),
    .trst_n_o(), .src_strap_o(s_strap), .width_strap_o(w_strap));
  rbmc_reset_boot #(.RELEASE_CYCLES(RC)) rbmc_reset_boot_i (.CLOCK_I(clk), .RST_N_I(rst_n),
    .BOOT_SOURCE_STRAP_I(s_strap), .EXT_MEM_WIDTH_STRAP_I(w_strap), .FLASH_UNSECURED_I(unsec),
    .BOOT_STRAP_PULLUP_DISABLE_I(bpd), .WIDTH_STRAP_PULLUP_DISABLE_I(wpd), .INT_RST_N_O(irst_n),
    .PROGRAM_MAP_SELECT_O(map), .SECURE_STATE_CAPTURE_O(sec), .EXT_MEM_WIDE_O(wide),
    .UPPER_ADDR_PIN_EN_O(pins), .BOOT_STRAP_PULLUP_EN_O(bpe), .WIDTH_STRAP_PULLUP_EN_O(wpe));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // secured flash turns an external request into internal boot
  function automatic logic [6:0] mode_of(input logic s, input logic w, input logic u);
    logic g;
    g = s & u;
    return {g, u, g & w, {4{g & w}}};
  endfunction
  // a hang costs at most a few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // each pass is a fresh reset, later ones land mid-run
  initial begin
    void'($urandom(32'h6f599bea));
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      hold = 1'b1;
      bpd = 1'b0;
      wpd = 1'b0;
      {src, wid, unsec} = (i < 8) ? i[2:0] : 3'($urandom);
      repeat (5) @(negedge clk);
      chk({irst_n, map, sec, wide, pins, bpe, wpe}, 10'h003, "in reset");
      hold = 1'b0;
      e = mode_of(src, wid, unsec);
      repeat (3) @(negedge clk);
      chk({map, sec, wide, pins}, e, "mode");
      repeat (RC - 1) @(negedge clk);
      chk(irst_n, 1'b0, "early release");
      @(negedge clk);
      chk(irst_n, 1'b1, "release");
      {src, wid, unsec} = ~{src, wid, unsec};
      bpd = ~src;
      wpd = ~wid;
      repeat (3) @(negedge clk);
      chk({map, sec, wide, pins}, e, "mode hold");
      chk({bpe, wpe}, {~bpd, ~wpd}, "pull-up");
    end
    wrap_up();
  end
endmodule
